// [verilog/coproc_xfer_pkg.sv]
// Constants for the coprocessor register transfer sequencer.
// Assumes a single core clock; the decoder presents one instruction at a time.
// Notes on behaviour
// - Transfer happens only when condition is true.
// - Coprocessor number picks the addressed coprocessor.
// - Opcode, info and register fields pass through.
// - Load to PC copies bits 31-28 to flags.
// - Load to PC changes nothing else.
// - Store from PC sends instruction address plus 12.
// - Load takes 1S, (b+1)I, 1C cycles.
// - Store takes 1S, bI, 1C cycles.
// - Direction bit one loads, zero stores.
// - True undefined instruction enters the undefined trap.
// - Undefined trap takes 2S, 1I, 1N cycles.
// - Coprocessor cycle drives request-n and burst high.
package coproc_xfer_pkg;
   localparam int          WORD_W      = 32;
   localparam int          FLAG_HI     = 31;
   localparam int          FLAG_LO     = 28;
   localparam logic [3:0]  PC_REG_NUM  = 4'hf;
   localparam logic [31:0] PC_STORE_OFS = 32'h0000_000c;
   localparam logic [1:0]  CYC_N       = 2'h0;
   localparam logic [1:0]  CYC_S       = 2'h1;
   localparam logic [1:0]  CYC_I       = 2'h2;
   localparam logic [1:0]  CYC_C       = 2'h3;
   typedef enum logic [2:0] {
      ST_IDLE, ST_FETCH, ST_WAIT, ST_XFER, ST_TRAP_S, ST_TRAP_I, ST_TRAP_N,
      ST_LOAD_I
   } seq_state_t;
endpackage : coproc_xfer_pkg

// [verilog/cycle_type_enc.sv]
// Encodes a cycle type onto the request-n and burst lines.
// Assumes the caller registers the outputs.
`timescale 1ns/1ps
module cycle_type_enc (
   input  wire logic [1:0] cyc_type,
   output logic            req_n,
   output logic            burst
);
   assign req_n = cyc_type[1];
   assign burst = cyc_type[0];
endmodule : cycle_type_enc

// [verilog/coproc_xfer.sv]
// Sequencer for register moves to and from a coprocessor, and the
// undefined-instruction trap. Instruction fields arrive already decoded;
// the condition result comes from the flag logic elsewhere in the core.
`timescale 1ns/1ps
module coproc_xfer (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        instr_valid,
   input  wire logic        cond_pass,
   input  wire logic        is_undef,
   input  wire logic        load_dir,
   input  wire logic [3:0]  coproc_number,
   input  wire logic [3:0]  core_reg_num,
   input  wire logic [31:0] core_reg_val,
   input  wire logic [31:0] instr_addr,
   input  wire logic        coproc_absent,
   input  wire logic        coproc_busy,
   input  wire logic [31:0] data_in,
   output logic             instr_done,
   output logic             mem_request_n,
   output logic             burst_indicator,
   output logic [3:0]       sel_coproc,
   output logic [31:0]      data_out,
   output logic             data_oe,
   output logic             reg_we,
   output logic [3:0]       reg_wnum,
   output logic [31:0]      reg_wdata,
   output logic             flags_we,
   output logic [3:0]       flags_nzcv,
   output logic             undef_trap
);
   ////////////////////////////////////////////////////////////////////////
   coproc_xfer_pkg::seq_state_t state_q;
   logic        load_q;
   logic [3:0]  rnum_q;
   logic [31:0] wdata_q;
   logic [1:0]  cyc_d;
   logic        req_n_d;
   logic        burst_d;

   cycle_type_enc u_enc (
      .cyc_type (cyc_d),
      .req_n    (req_n_d),
      .burst    (burst_d)
   );

   // Cycle type for each state. Waiting on busy is an internal cycle.
   always_comb begin
      case (state_q)
         coproc_xfer_pkg::ST_FETCH:  cyc_d = coproc_xfer_pkg::CYC_S;
         coproc_xfer_pkg::ST_XFER:   cyc_d = coproc_xfer_pkg::CYC_C;
         coproc_xfer_pkg::ST_TRAP_S: cyc_d = coproc_xfer_pkg::CYC_S;
         coproc_xfer_pkg::ST_TRAP_N: cyc_d = coproc_xfer_pkg::CYC_N;
         default:   cyc_d = coproc_xfer_pkg::CYC_I;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencing. Fetch is the S cycle; then the coprocessor answers.
   // A load spends one extra internal cycle before the coprocessor cycle.
   logic trap_s2_q;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state_q   <= coproc_xfer_pkg::ST_IDLE;
         trap_s2_q <= 1'b0;
      end else begin
         case (state_q)
            coproc_xfer_pkg::ST_IDLE: begin
               if (instr_valid && cond_pass)
                  state_q <= coproc_xfer_pkg::ST_FETCH;
            end
            coproc_xfer_pkg::ST_FETCH: begin
               if (is_undef || coproc_absent) begin
                  state_q   <= coproc_xfer_pkg::ST_TRAP_S;
                  trap_s2_q <= 1'b0;
               end else if (coproc_busy)
                  state_q <= coproc_xfer_pkg::ST_WAIT;
               else
                  state_q <= load_q ? coproc_xfer_pkg::ST_LOAD_I
                                    : coproc_xfer_pkg::ST_XFER;
            end
            coproc_xfer_pkg::ST_WAIT: begin
               if (coproc_absent)
                  state_q <= coproc_xfer_pkg::ST_TRAP_S;
               else if (!coproc_busy)
                  state_q <= load_q ? coproc_xfer_pkg::ST_LOAD_I
                                    : coproc_xfer_pkg::ST_XFER;
            end
            coproc_xfer_pkg::ST_LOAD_I: begin
               state_q <= coproc_xfer_pkg::ST_XFER;
            end
            coproc_xfer_pkg::ST_XFER: begin
               state_q <= coproc_xfer_pkg::ST_IDLE;
            end
            // The pair flag is cleared on the way out, so a trap entered
            // from the busy wait also gets both of its S cycles.
            coproc_xfer_pkg::ST_TRAP_S: begin
               if (trap_s2_q) begin
                  state_q   <= coproc_xfer_pkg::ST_TRAP_I;
                  trap_s2_q <= 1'b0;
               end else begin
                  trap_s2_q <= 1'b1;
               end
            end
            coproc_xfer_pkg::ST_TRAP_I: begin
               state_q <= coproc_xfer_pkg::ST_TRAP_N;
            end
            default: begin
               state_q <= coproc_xfer_pkg::ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Latch the instruction. Opcode and coprocessor register fields are
   // not seen here; they travel to the coprocessor with the fetch.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         load_q     <= 1'b0;
         rnum_q     <= 4'h0;
         wdata_q    <= 32'h0000_0000;
         sel_coproc <= 4'h0;
      end else if (state_q == coproc_xfer_pkg::ST_IDLE && instr_valid
                   && cond_pass) begin
         load_q     <= load_dir;
         rnum_q     <= core_reg_num;
         sel_coproc <= coproc_number;
         if (core_reg_num == coproc_xfer_pkg::PC_REG_NUM)
            wdata_q <= instr_addr + coproc_xfer_pkg::PC_STORE_OFS;
         else
            wdata_q <= core_reg_val;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         mem_request_n   <= 1'b1;
         burst_indicator <= 1'b0;
         data_out        <= 32'h0000_0000;
         data_oe         <= 1'b0;
      end else begin
         mem_request_n   <= req_n_d;
         burst_indicator <= burst_d;
         data_out        <= wdata_q;
         data_oe         <= (state_q == coproc_xfer_pkg::ST_XFER) && !load_q;
      end
   end

   logic xfer_ld;
   assign xfer_ld = (state_q == coproc_xfer_pkg::ST_XFER) && load_q;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         reg_we     <= 1'b0;
         reg_wnum   <= 4'h0;
         reg_wdata  <= 32'h0000_0000;
         flags_we   <= 1'b0;
         flags_nzcv <= 4'h0;
         instr_done <= 1'b0;
         undef_trap <= 1'b0;
      end else begin
         // Loads to the PC only touch the flags.
         reg_we     <= xfer_ld && rnum_q != coproc_xfer_pkg::PC_REG_NUM;
         reg_wnum   <= rnum_q;
         reg_wdata  <= data_in;
         flags_we   <= xfer_ld && rnum_q == coproc_xfer_pkg::PC_REG_NUM;
         flags_nzcv <= data_in[coproc_xfer_pkg::FLAG_HI:
                               coproc_xfer_pkg::FLAG_LO];
         instr_done <= state_q == coproc_xfer_pkg::ST_XFER ||
                       state_q == coproc_xfer_pkg::ST_TRAP_N ||
                       (state_q == coproc_xfer_pkg::ST_IDLE && instr_valid
                        && !cond_pass);
         undef_trap <= state_q == coproc_xfer_pkg::ST_TRAP_N;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_fetch_accept;
      state_q == coproc_xfer_pkg::ST_FETCH && !is_undef && !coproc_absent
      && !coproc_busy;
   endsequence

   sequence s_trap_s_pair;
      state_q == coproc_xfer_pkg::ST_TRAP_S
      ##1 state_q == coproc_xfer_pkg::ST_TRAP_S;
   endsequence

   a_cond_false_idle: assert property (
      @(posedge core_clk) disable iff (!nrst)
      state_q == coproc_xfer_pkg::ST_IDLE && instr_valid && !cond_pass
      |=> state_q == coproc_xfer_pkg::ST_IDLE)
      else $error("failed condition started a transfer");
   a_coproc_cycle_pins: assert property (
      @(posedge core_clk) disable iff (!nrst)
      state_q == coproc_xfer_pkg::ST_XFER
      |=> mem_request_n && burst_indicator)
      else $error("coprocessor cycle not signalled");
   a_pc_flags_only: assert property (
      @(posedge core_clk) disable iff (!nrst)
      xfer_ld && rnum_q == coproc_xfer_pkg::PC_REG_NUM
      |=> flags_we && !reg_we
      && flags_nzcv == $past(data_in[coproc_xfer_pkg::FLAG_HI:
                                     coproc_xfer_pkg::FLAG_LO]))
      else $error("load to pc mishandled");
   a_pc_no_write: assert property (
      @(posedge core_clk) disable iff (!nrst)
      reg_we |-> reg_wnum != coproc_xfer_pkg::PC_REG_NUM)
      else $error("pc written by transfer");
   a_load_timing: assert property (
      @(posedge core_clk) disable iff (!nrst)
      s_fetch_accept ##0 load_q |=> state_q == coproc_xfer_pkg::ST_LOAD_I
      ##1 state_q == coproc_xfer_pkg::ST_XFER)
      else $error("load cycle count wrong");
   a_store_timing: assert property (
      @(posedge core_clk) disable iff (!nrst)
      s_fetch_accept ##0 !load_q
      |=> state_q == coproc_xfer_pkg::ST_XFER ##1 data_oe)
      else $error("store cycle count wrong");
   a_trap_length: assert property (
      @(posedge core_clk) disable iff (!nrst)
      state_q == coproc_xfer_pkg::ST_FETCH && (is_undef || coproc_absent)
      |=> ##3 state_q == coproc_xfer_pkg::ST_TRAP_N ##1 undef_trap)
      else $error("trap length wrong");
   a_trap_s_pair: assert property (
      @(posedge core_clk) disable iff (!nrst)
      state_q != coproc_xfer_pkg::ST_TRAP_S ##1 s_trap_s_pair
      |=> state_q == coproc_xfer_pkg::ST_TRAP_I)
      else $error("trap s cycle count wrong");
   a_busy_waits: assert property (
      @(posedge core_clk) disable iff (!nrst)
      state_q == coproc_xfer_pkg::ST_WAIT && coproc_busy && !coproc_absent
      |=> state_q == coproc_xfer_pkg::ST_WAIT)
      else $error("left busy wait early");
   a_pc_store_value: assert property (
      @(posedge core_clk) disable iff (!nrst)
      state_q == coproc_xfer_pkg::ST_IDLE && instr_valid && cond_pass
      && core_reg_num == coproc_xfer_pkg::PC_REG_NUM
      |=> wdata_q == $past(instr_addr) + coproc_xfer_pkg::PC_STORE_OFS)
      else $error("pc store value wrong");
endmodule : coproc_xfer

// [verification/coproc_model.sv]
// Behavioural attached coprocessor answering the transfer sequencer.
// Assumes the bench raises start at the edge where an instruction is taken.
`timescale 1ns/1ps
module coproc_model (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        start,
   input  wire logic        done,
   input  wire logic        is_undef,
   input  wire logic [3:0]  coproc_number,
   input  wire logic [3:0]  my_num,
   input  wire logic [3:0]  busy_len,
   input  wire logic [31:0] word,
   output logic             coproc_absent,
   output logic             coproc_busy,
   output logic [31:0]      data_in
);
   logic [3:0] cnt_q;
   logic       act_q;
   always_ff @(posedge core_clk) begin
      if (!nrst || start) cnt_q <= nrst ? busy_len : 4'h0;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
   end
   always_ff @(posedge core_clk) begin
      if (!nrst || done) act_q <= 1'b0;
      else if (start) act_q <= 1'b1;
   end
   // Only the addressed unit accepts; undefined work is refused outright.
   assign coproc_absent = is_undef || coproc_number != my_num;
   assign coproc_busy = coproc_absent || cnt_q != 4'h0;
   // Outside a transfer the bus is not held, so show the inverted word.
   assign data_in = act_q ? word : ~word;
endmodule : coproc_model

// [verification/coproc_xfer_tb_top.sv]
// Self-checking bench for the coprocessor register transfer sequencer.
// Assumes the coprocessor model beside it stands for the far side.
`timescale 1ns/1ps
module coproc_xfer_tb_top;
   localparam logic [3:0] MY_NUM = 4'h5;
   logic core_clk = 1'b0, nrst = 1'b0, instr_valid = 1'b0, cond_pass = 1'b0;
   logic is_undef = 1'b0, load_dir = 1'b0, coproc_absent, coproc_busy;
   logic [3:0] coproc_number = 4'h0, core_reg_num = 4'h0, busy_len = 4'h0;
   logic [31:0] core_reg_val = 32'h0000_0000, instr_addr = 32'h0000_0000;
   logic [31:0] word = 32'h0000_0000, data_in, data_out, reg_wdata;
   logic instr_done, mem_request_n, burst_indicator, data_oe, reg_we;
   logic flags_we, undef_trap;
   logic [3:0] sel_coproc, reg_wnum, flags_nzcv;
   logic [31:0] seed = 32'h9fea_3ea1;
   int error_cnt = 0, total_checks = 0, test_no = 0;
   always #5 core_clk = ~core_clk;
   coproc_xfer dut_u (.core_clk(core_clk), .nrst(nrst),
      .instr_valid(instr_valid), .cond_pass(cond_pass), .is_undef(is_undef),
      .load_dir(load_dir), .coproc_number(coproc_number),
      .core_reg_num(core_reg_num), .core_reg_val(core_reg_val),
      .instr_addr(instr_addr), .coproc_absent(coproc_absent),
      .coproc_busy(coproc_busy), .data_in(data_in), .instr_done(instr_done),
      .mem_request_n(mem_request_n), .burst_indicator(burst_indicator),
      .sel_coproc(sel_coproc), .data_out(data_out), .data_oe(data_oe),
      .reg_we(reg_we), .reg_wnum(reg_wnum), .reg_wdata(reg_wdata),
      .flags_we(flags_we), .flags_nzcv(flags_nzcv), .undef_trap(undef_trap));
   coproc_model peer_u (.core_clk(core_clk), .nrst(nrst), .start(instr_valid),
      .done(instr_done), .is_undef(is_undef), .coproc_number(coproc_number),
      .my_num(MY_NUM), .busy_len(busy_len), .word(word),
      .coproc_absent(coproc_absent), .coproc_busy(coproc_busy),
      .data_in(data_in));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic chk_int(input string what, input int exp, input int got);
      total_checks++;
      if (exp != got) begin
         error_cnt++;
         $display("unexpected %s: expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_int
   task automatic chk32(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      total_checks++;
      if (exp !== got) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk32
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////
   task automatic run(input logic ld, input logic [3:0] cp,
                      input logic [3:0] rn, input logic cnd,
                      input logic und, input logic [3:0] b);
      int k, ni, nc, nn, t_oe, t_we, t_fl, t_tr;
      logic trap;
      logic [31:0] exp_out;
      @(negedge core_clk);
      {load_dir, coproc_number, core_reg_num} = {ld, cp, rn};
      {cond_pass, is_undef, busy_len} = {cnd, und, b};
      core_reg_val = rnd();
      instr_addr = rnd();
      word = rnd();
      instr_valid = 1'b1;
      {ni, nc, nn} = {32'd0, 32'd0, 32'd0};
      {t_oe, t_we, t_fl, t_tr} = {-32'sd1, -32'sd1, -32'sd1, -32'sd1};
      trap = cnd && (und || cp != MY_NUM);
      exp_out = (rn == 4'hf) ? instr_addr + coproc_xfer_pkg::PC_STORE_OFS
                             : core_reg_val;
      for (k = 0; k < 40; k++) begin
         @(negedge core_clk);
         instr_valid = 1'b0;
         if (data_oe === 1'b1) t_oe = k;
         if (data_oe === 1'b1) chk32("data_out", exp_out, data_out);
         if (reg_we === 1'b1) t_we = k;
         if (reg_we === 1'b1) chk32("reg_wdata", word, reg_wdata);
         if (reg_we === 1'b1)
            chk32("reg_wnum", {28'h0, rn}, {28'h0, reg_wnum});
         if (flags_we === 1'b1) t_fl = k;
         if (flags_we === 1'b1) chk32("flags", {28'h0, word[31:28]},
                                      {28'h0, flags_nzcv});
         if (undef_trap === 1'b1) t_tr = k;
         if (k >= 2 && {mem_request_n, burst_indicator} === 2'b10) ni++;
         if (k >= 2 && {mem_request_n, burst_indicator} === 2'b11) nc++;
         if (k >= 2 && {mem_request_n, burst_indicator} === 2'b00) nn++;
         if (instr_done === 1'b1 || undef_trap === 1'b1) break;
      end
      if (k == 40) chk_int("completion", 0, 1);
      if (k == 40) report_and_stop();
      repeat (2) @(negedge core_clk);
      if (!cnd) begin
         chk_int("skipped activity", -4, t_oe + t_we + t_fl + t_tr);
      end else if (trap) begin
         chk_int("trap edge", 5, t_tr);
         chk_int("trap cycles", 2, ni + nn + nc);
         chk_int("trap moved data", -3, t_oe + t_we + t_fl);
      end else begin
         chk32("sel_coproc", {28'h0, cp}, {28'h0, sel_coproc});
         chk_int("c cycles", 1, nc);
         chk_int("i cycles", ld ? b + 1 : b, ni);
         if (!ld) chk_int("store edge", 2 + int'(b), t_oe);
         if (ld && rn == 4'hf)
            chk_int("pc load", -4 - int'(b), t_we - t_fl);
         if (ld && rn != 4'hf)
            chk_int("load edge", 3 + int'(b), t_we);
      end
      test_no++;
      $display("test %0d finished", test_no);
   endtask : run
   initial begin : main
      logic [31:0] r;
      repeat (20) @(negedge core_clk);
      nrst = 1'b1;
      run(1'b0, MY_NUM, 4'hf, 1'b1, 1'b0, 4'h0);
      run(1'b1, MY_NUM, 4'hf, 1'b1, 1'b0, 4'h0);
      run(1'b1, MY_NUM, 4'h3, 1'b1, 1'b0, 4'h3);
      run(1'b0, MY_NUM, 4'h4, 1'b1, 1'b0, 4'h5);
      run(1'b0, MY_NUM, 4'h1, 1'b1, 1'b1, 4'h0);
      run(1'b1, 4'h9, 4'h2, 1'b1, 1'b0, 4'h0);
      run(1'b0, MY_NUM, 4'h2, 1'b0, 1'b0, 4'h0);
      run(1'b1, MY_NUM, 4'h2, 1'b0, 1'b1, 4'h0);
      repeat (16) begin
         r = rnd();
         run(r[0], (r[10:8] == 3'h0) ? 4'h9 : MY_NUM, r[1] ? 4'hf : r[7:4],
             r[13:11] != 3'h0, r[16:15] == 2'h0, {2'h0, r[19:18]});
      end
      report_and_stop();
   end
endmodule : coproc_xfer_tb_top
